/* File: design/rcs_pkg.sv */
// Shared constants and types of the register commit and nv sequencer
package rcs_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_SYS_CTRL = 12'h230;
    localparam logic [11:0] ADDR_UPDATE = 12'h232;
    localparam logic [11:0] ADDR_TBL_FIRST = 12'ha00;
    localparam logic [11:0] ADDR_TBL_LAST = 12'haff;
    localparam logic [11:0] ADDR_XFER_STAT = 12'hb00;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int SYS_ANTIRUNT_DIS_BIT = 3;
    localparam int SYS_SYNC_PDN_BIT = 2;
    localparam int SYS_DREF_PDN_BIT = 1;
    localparam int SYS_SOFT_SYNC_BIT = 0;
    localparam int UPDATE_BIT = 0;
    localparam int XFER_STAT_BIT = 0;
    localparam int CMD_OP_BIT = 7;
    localparam logic [7:0] SYS_CTRL_RST = 8'h00;

    // ------------------------------------------------------------
    // Command table encodings
    // ------------------------------------------------------------
    localparam logic [7:0] OP_COMMIT = 8'h80;
    localparam logic [7:0] OP_END = 8'hff;
    localparam int TBL_DEPTH = 256;

    // Power-on table: all register spans, then commit, then end
    function automatic logic [7:0] tbl_default(input logic [7:0] idx);
        case (idx)
            8'h00, 8'h03, 8'h06, 8'h09: tbl_default = 8'h7f;
            8'h01, 8'h02, 8'h04, 8'h08, 8'h0e: tbl_default = 8'h00;
            8'h05, 8'h0b: tbl_default = 8'h80;
            8'h07, 8'h0a: tbl_default = 8'h01;
            8'h0c: tbl_default = 8'h32;
            8'h0d: tbl_default = 8'h02;
            8'h0f: tbl_default = OP_COMMIT;
            default: tbl_default = OP_END;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic we;
        logic re;
        logic [11:0] addr;
        logic [7:0] wdata;
    } rcs_reg_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] addr;
        logic [7:0] len;
    } rcs_span_t;

    typedef struct packed {
        logic [7:0] sys;
        logic antirunt_en;
        logic upd;
        logic sync_hold;
        logic sync_event;
        logic commit;
        logic [7:0] rdata;
        logic [TBL_DEPTH-1:0][7:0] tbl;
    } rcs_main_st_t;

    typedef enum logic [2:0] {
        SQ_IDLE, SQ_CMD, SQ_ADDR_HI, SQ_ADDR_LO, SQ_WAIT
    } rcs_seq_state_t;

    typedef struct packed {
        rcs_seq_state_t state;
        logic [8:0] idx;
        rcs_span_t span;
        logic commit;
        logic busy;
    } rcs_seq_st_t;

endpackage

/* File: design/rcs_table_walker.sv */
// Command table walker that feeds spans to the nv controller
`timescale 1ns/1ps
`default_nettype none

module rcs_table_walker (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Transfer request and table access
    input wire logic nv_start,
    output logic [7:0] tbl_idx,
    input wire logic [7:0] tbl_byte,
    // Span handshake with the nv controller
    output rcs_pkg::rcs_span_t span,
    input wire logic span_done,
    // Results
    output logic seq_commit,
    output logic busy
);

    rcs_pkg::rcs_seq_st_t st, next_st;

    assign tbl_idx = st.idx[7:0];
    assign span = st.span;
    assign seq_commit = st.commit;
    assign busy = st.busy;

    // ------------------------------------------------------------
    // Walk
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.commit = 1'b0;
        case (st.state)
            rcs_pkg::SQ_IDLE: begin
                if (nv_start) begin
                    next_st.idx = 9'h000;
                    next_st.state = rcs_pkg::SQ_CMD;
                end
            end
            rcs_pkg::SQ_CMD: begin
                if (st.idx[8]) begin
                    next_st.state = rcs_pkg::SQ_IDLE;
                // [R9] Data transfer entry
                end else if (!tbl_byte[rcs_pkg::CMD_OP_BIT]) begin
                    next_st.span.len = {1'b0, tbl_byte[6:0]} + 8'h01;
                    // [R17] Advance past command
                    next_st.idx = st.idx + 9'h001;
                    next_st.state = rcs_pkg::SQ_ADDR_HI;
                // [R12] Commit opcode
                end else if (tbl_byte == rcs_pkg::OP_COMMIT) begin
                    next_st.commit = 1'b1;
                    next_st.idx = st.idx + 9'h001;
                // [R11] [R13] End or unknown opcode stops
                end else begin
                    next_st.state = rcs_pkg::SQ_IDLE;
                end
            end
            // [R10] Start address, high byte first
            rcs_pkg::SQ_ADDR_HI: begin
                next_st.span.addr[15:8] = tbl_byte;
                next_st.idx = st.idx + 9'h001;
                next_st.state = st.idx[8] ? rcs_pkg::SQ_IDLE
                                          : rcs_pkg::SQ_ADDR_LO;
            end
            rcs_pkg::SQ_ADDR_LO: begin
                next_st.span.addr[7:0] = tbl_byte;
                next_st.idx = st.idx + 9'h001;
                next_st.span.valid = !st.idx[8];
                next_st.state = st.idx[8] ? rcs_pkg::SQ_IDLE
                                          : rcs_pkg::SQ_WAIT;
            end
            rcs_pkg::SQ_WAIT: begin
                if (span_done) begin
                    next_st.span.valid = 1'b0;
                    next_st.state = rcs_pkg::SQ_CMD;
                end
            end
            default: next_st.state = rcs_pkg::SQ_IDLE;
        endcase
        // [R16] Busy while walking
        next_st.busy = (next_st.state != rcs_pkg::SQ_IDLE);
        if (!rstn) begin
            next_st = '0;
            next_st.state = rcs_pkg::SQ_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_span_length: assert property (@(posedge clk) disable iff (!rstn) // [R9]
        st.state == rcs_pkg::SQ_CMD && !st.idx[8] && !tbl_byte[7]
        |=> st.span.len == {1'b0, $past(tbl_byte[6:0])} + 8'h01)
        else $error("span length not command field plus one");
    a_addr_msb_first: assert property ( // [R10]
        @(posedge clk) disable iff (!rstn)
        $rose(st.span.valid)
        |-> st.span.addr == {$past(tbl_byte, 2), $past(tbl_byte)})
        else $error("span address bytes out of order");
    a_end_stops: assert property (@(posedge clk) disable iff (!rstn) // [R13]
        st.state == rcs_pkg::SQ_CMD && tbl_byte == rcs_pkg::OP_END
        |=> st.state == rcs_pkg::SQ_IDLE && !busy)
        else $error("end opcode did not stop the walk");
    a_op_commit: assert property (@(posedge clk) disable iff (!rstn) // [R11]
        st.state == rcs_pkg::SQ_CMD && !st.idx[8]
        && tbl_byte == rcs_pkg::OP_COMMIT |=> seq_commit)
        else $error("commit opcode gave no commit");
    a_idx_advance: assert property (@(posedge clk) disable iff (!rstn) // [R17]
        st.state == rcs_pkg::SQ_ADDR_HI |=> st.idx == $past(st.idx) + 9'h001
        ##1 st.idx == $past(st.idx, 2) + 9'h002)
        else $error("table index did not advance");
    a_busy_start: assert property (@(posedge clk) disable iff (!rstn) // [R16]
        st.state == rcs_pkg::SQ_IDLE && nv_start
        |=> busy && st.idx == 9'h000)
        else $error("busy not raised on start");
    c_span_done: cover property (@(posedge clk) disable iff (!rstn)
        st.span.valid && span_done);
    c_walk_ends: cover property (@(posedge clk) disable iff (!rstn)
        $fell(busy));

endmodule // rcs_table_walker

`default_nettype wire

/* File: design/rcs_commit_sequencer.sv */
// Alignment control, register commit and nv command table
`timescale 1ns/1ps
`default_nettype none
// Operation
// [R1] A high alignment bit holds channels static and its fall fires one event.
// [R2] The alignment bit acts as the alignment pin inverted.
// [R3] Control bit 3 set disables the anti-runt circuitry, clear enables it.
// [R4] Control bit 2 set powers the alignment circuitry down.
// [R5] Control bit 1 set powers down the distribution reference.
// [R6] Writing one to the update bit commits on the next serial clock rise.
// [R7] The update bit clears itself after the commit.
// [R8] A 256-byte command table lists spans for the nv controller.
// [R9] A command byte with bit 7 clear is a span of field plus one bytes.
// [R10] The two bytes after a span command are its address, high byte first.
// [R11] A command byte with bit 7 set is the commit or end opcode.
// [R12] The commit opcode commits just like the update bit.
// [R13] The end opcode stops the walk and ends the transfer.
// [R14] Software rewriting the table ends it with an end opcode.
// [R15] At power-on the table moves every register and then commits.
// [R16] The transfer status bit reads one while a save or restore runs.
// [R17] Entries are walked in order from the lowest table address.

module rcs_commit_sequencer (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register access from the serial port
    input wire rcs_pkg::rcs_reg_req_t reg_req,
    input wire logic sclk_rise,
    output logic [7:0] reg_rdata,
    // Distribution controls
    output logic sync_hold,
    output logic sync_event,
    output logic antirunt_en,
    output logic sync_pdn,
    output logic dist_ref_pdn,
    output logic commit_pulse,
    // Nonvolatile controller side
    input wire logic nv_start,
    output rcs_pkg::rcs_span_t span,
    input wire logic span_done,
    output logic xfer_busy
);

    rcs_pkg::rcs_main_st_t st, next_st;
    logic [7:0] tbl_idx;
    logic [7:0] tbl_byte;
    logic seq_commit;
    logic upd_wr;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic in_tbl(input logic [11:0] a);
        in_tbl = (a >= rcs_pkg::ADDR_TBL_FIRST)
              && (a <= rcs_pkg::ADDR_TBL_LAST);
    endfunction

    function automatic rcs_pkg::rcs_main_st_t rst_state();
        rst_state = '0;
        rst_state.sys = rcs_pkg::SYS_CTRL_RST;
        rst_state.antirunt_en =
            !rcs_pkg::SYS_CTRL_RST[rcs_pkg::SYS_ANTIRUNT_DIS_BIT];
        for (int i = 0; i < rcs_pkg::TBL_DEPTH; i++) begin
            rst_state.tbl[i] = rcs_pkg::tbl_default(i[7:0]);
        end
    endfunction

    assign tbl_byte = st.tbl[tbl_idx];
    assign upd_wr = reg_req.we && reg_req.addr == rcs_pkg::ADDR_UPDATE
                 && reg_req.wdata[rcs_pkg::UPDATE_BIT];

    // ------------------------------------------------------------
    // Table walker
    // ------------------------------------------------------------
    rcs_table_walker u_walker (
        .clk(clk),
        .rstn(rstn),
        .nv_start(nv_start),
        .tbl_idx(tbl_idx),
        .tbl_byte(tbl_byte),
        .span(span),
        .span_done(span_done),
        .seq_commit(seq_commit),
        .busy(xfer_busy)
    );

    // ------------------------------------------------------------
    // Registers and control
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        if (reg_req.we && reg_req.addr == rcs_pkg::ADDR_SYS_CTRL) begin
            next_st.sys = {4'h0, reg_req.wdata[3:0]};
        end
        // [R3] Anti-runt enable, inverse of bit 3
        next_st.antirunt_en = !next_st.sys[rcs_pkg::SYS_ANTIRUNT_DIS_BIT];
        // [R8] Table writes, byte per offset
        if (reg_req.we && in_tbl(reg_req.addr)) begin
            next_st.tbl[reg_req.addr[7:0]] = reg_req.wdata;
        end
        // [R7] Cleared by the commit edge, a new write wins
        if (upd_wr) begin
            next_st.upd = 1'b1;
        end else if (sclk_rise) begin
            next_st.upd = 1'b0;
        end
        // [R6] [R12] Commit on serial edge or opcode
        next_st.commit = (st.upd && sclk_rise) || seq_commit;
        // [R1] [R2] [R4] Hold and event, gated by power-down
        next_st.sync_hold = next_st.sys[rcs_pkg::SYS_SOFT_SYNC_BIT]
                         && !next_st.sys[rcs_pkg::SYS_SYNC_PDN_BIT];
        next_st.sync_event = st.sync_hold && !next_st.sync_hold
                          && !next_st.sys[rcs_pkg::SYS_SYNC_PDN_BIT];
        if (reg_req.re) begin
            next_st.rdata = 8'h00;
            if (reg_req.addr == rcs_pkg::ADDR_SYS_CTRL) begin
                next_st.rdata = st.sys;
            end else if (reg_req.addr == rcs_pkg::ADDR_UPDATE) begin
                next_st.rdata = {7'h00, st.upd};
            end else if (in_tbl(reg_req.addr)) begin
                next_st.rdata = st.tbl[reg_req.addr[7:0]];
            // [R16] Transfer status readback
            end else if (reg_req.addr == rcs_pkg::ADDR_XFER_STAT) begin
                next_st.rdata = {7'h00, xfer_busy};
            end
        end
        // [R15] Default table at reset
        if (!rstn) begin
            next_st = rst_state();
        end
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata = st.rdata;
    assign sync_hold = st.sync_hold;
    assign sync_event = st.sync_event;
    // [R3] Anti-runt enable is the inverse of bit 3
    assign antirunt_en = st.antirunt_en;
    assign sync_pdn = st.sys[rcs_pkg::SYS_SYNC_PDN_BIT];
    // [R5] Distribution reference power-down
    assign dist_ref_pdn = st.sys[rcs_pkg::SYS_DREF_PDN_BIT];
    assign commit_pulse = st.commit;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_commit_on_sclk: assert property ( // [R6]
        @(posedge clk) disable iff (!rstn)
        st.upd && sclk_rise |=> commit_pulse)
        else $error("update did not commit on serial edge");
    a_update_clears: assert property ( // [R7]
        @(posedge clk) disable iff (!rstn)
        st.upd && sclk_rise && !upd_wr
        |=> !st.upd ##1 (!st.upd || $past(upd_wr)))
        else $error("update bit did not clear");
    a_opcode_commit: assert property ( // [R12]
        @(posedge clk) disable iff (!rstn)
        seq_commit |=> commit_pulse)
        else $error("opcode commit lost");
    a_sync_event_fall: assert property ( // [R1]
        @(posedge clk) disable iff (!rstn)
        reg_req.we && reg_req.addr == rcs_pkg::ADDR_SYS_CTRL
        && reg_req.wdata[2:0] == 3'b000 && st.sys[2:0] == 3'b001
        |=> sync_event && !sync_hold ##1 !sync_event)
        else $error("alignment event missing on fall");
    a_sync_inverted: assert property ( // [R2]
        @(posedge clk) disable iff (!rstn)
        reg_req.we && reg_req.addr == rcs_pkg::ADDR_SYS_CTRL
        && reg_req.wdata[2:0] == 3'b001 |=> sync_hold && !sync_event)
        else $error("alignment bit high did not hold outputs");
    a_antirunt_bit: assert property (@(posedge clk) disable iff (!rstn) // [R3]
        reg_req.we && reg_req.addr == rcs_pkg::ADDR_SYS_CTRL
        |=> antirunt_en == !$past(reg_req.wdata[3]))
        else $error("anti-runt enable wrong");
    a_sync_pdn_bit: assert property (@(posedge clk) disable iff (!rstn) // [R4]
        reg_req.we && reg_req.addr == rcs_pkg::ADDR_SYS_CTRL
        && reg_req.wdata[2] |=> sync_pdn && !sync_hold)
        else $error("alignment power-down wrong");
    a_dref_pdn_bit: assert property (@(posedge clk) disable iff (!rstn) // [R5]
        reg_req.we && reg_req.addr == rcs_pkg::ADDR_SYS_CTRL
        |=> dist_ref_pdn == $past(reg_req.wdata[1]))
        else $error("reference power-down wrong");
    a_table_default: assert property (@(posedge clk) // [R15]
        !rstn |=> st.tbl[15] == rcs_pkg::OP_COMMIT
        && st.tbl[255] == rcs_pkg::OP_END && st.tbl[0] == 8'h7f)
        else $error("default table not loaded");
    a_status_read: assert property (@(posedge clk) disable iff (!rstn) // [R16]
        reg_req.re && reg_req.addr == rcs_pkg::ADDR_XFER_STAT
        |=> reg_rdata == {7'h00, $past(xfer_busy)})
        else $error("transfer status readback wrong");
    a_pdn_quiet: assert property (@(posedge clk) disable iff (!rstn) // [R4]
        sync_pdn |-> !sync_hold && !sync_event)
        else $error("alignment active while powered down");
    a_sys_readback: assert property (@(posedge clk) disable iff (!rstn) // [R3]
        reg_req.we && reg_req.addr == rcs_pkg::ADDR_SYS_CTRL
        ##1 reg_req.re && reg_req.addr == rcs_pkg::ADDR_SYS_CTRL
        |=> reg_rdata == {4'h0, $past(reg_req.wdata[3:0], 2)})
        else $error("control readback wrong");
    a_table_rw: assert property (@(posedge clk) disable iff (!rstn) // [R8]
        reg_req.we && in_tbl(reg_req.addr) ##1 reg_req.re && !reg_req.we
        && reg_req.addr == $past(reg_req.addr)
        |=> reg_rdata == $past(reg_req.wdata, 2))
        else $error("table byte readback wrong");
    a_upd_set: assert property (@(posedge clk) disable iff (!rstn) // [R6]
        upd_wr |=> st.upd)
        else $error("update request not held");
    a_busy_cause: assert property (@(posedge clk) disable iff (!rstn) // [R16]
        !xfer_busy && !nv_start |=> !xfer_busy)
        else $error("transfer status rose without a start");
    c_sclk_commit: cover property (@(posedge clk) disable iff (!rstn)
        st.upd && sclk_rise);
    c_sync_event: cover property (@(posedge clk) disable iff (!rstn)
        sync_event);
    c_seq_commit: cover property (@(posedge clk) disable iff (!rstn)
        seq_commit);

endmodule // rcs_commit_sequencer

`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench for the register commit and nv sequencer
`timescale 1ns/1ps
`default_nettype none

module testbench;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic sclk_rise = 1'b0;
    logic nv_start = 1'b0;
    logic span_done = 1'b0;
    rcs_pkg::rcs_reg_req_t reg_req = '0;
    rcs_pkg::rcs_span_t span;
    logic [7:0] reg_rdata;
    logic sync_hold, sync_event, antirunt_en, sync_pdn, dist_ref_pdn;
    logic commit_pulse, xfer_busy;
    int err_count = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [15:0] ex_addr [8];
    logic [7:0] ex_len [8];

    always #5 clk = ~clk;

    rcs_commit_sequencer rcs_commit_sequencer_i (
        .clk(clk), .rstn(rstn), .reg_req(reg_req), .sclk_rise(sclk_rise),
        .reg_rdata(reg_rdata), .sync_hold(sync_hold),
        .sync_event(sync_event), .antirunt_en(antirunt_en),
        .sync_pdn(sync_pdn), .dist_ref_pdn(dist_ref_pdn),
        .commit_pulse(commit_pulse), .nv_start(nv_start), .span(span),
        .span_done(span_done), .xfer_busy(xfer_busy)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            $display("CHECK FAILED timeout expected end seen hang");
            end_of_test();
        end
    end

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One bus cycle; called and returns just after a rising edge
    task automatic bus(input logic w, input logic r,
                       input logic [11:0] a, input logic [7:0] d);
        reg_req = '{we: w, re: r, addr: a, wdata: d};
        @(posedge clk);
        #1;
    endtask

    task automatic rdchk(input string what, input logic [11:0] a,
                         input logic [7:0] exp);
        bus(1'b0, 1'b1, a, 8'h00);
        chk(what, {8'h00, exp}, {8'h00, reg_rdata});
        bus(1'b0, 1'b0, 12'h000, 8'h00);
    endtask

    // Start a walk, answer each span, count spans and commits
    task automatic walk(input int n_sp, input int n_cm);
        int sp;
        int cm;
        int k;
        sp = 0;
        cm = 0;
        nv_start = 1'b1;
        @(posedge clk);
        #1 nv_start = 1'b0;
        chk("xfer_busy", 16'h0001, {15'h0, xfer_busy});
        rdchk("xfer_stat", rcs_pkg::ADDR_XFER_STAT, 8'h01);
        for (k = 0; k < 3000 && xfer_busy === 1'b1; k++) begin
            if (span_done === 1'b1) begin
                span_done = 1'b0;
            end else if (span.valid === 1'b1) begin
                chk("span_addr", ex_addr[sp % 8], span.addr);
                chk("span_len", {8'h00, ex_len[sp % 8]},
                    {8'h00, span.len});
                span_done = 1'b1;
                sp++;
            end
            @(posedge clk);
            #1;
            if (commit_pulse === 1'b1) cm++;
        end
        span_done = 1'b0;
        repeat (4) begin
            @(posedge clk);
            #1;
            if (commit_pulse === 1'b1) cm++;
        end
        chk("span_count", n_sp[15:0], sp[15:0]);
        chk("commit_count", n_cm[15:0], cm[15:0]);
        chk("xfer_busy", 16'h0000, {15'h0, xfer_busy});
        rdchk("xfer_stat", rcs_pkg::ADDR_XFER_STAT, 8'h00);
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        #1 rstn = 1'b1;
        chk("antirunt_en", 16'h0001, {15'h0, antirunt_en});
        chk("sync_pdn", 16'h0000, {15'h0, sync_pdn});
        chk("dist_ref_pdn", 16'h0000, {15'h0, dist_ref_pdn});
        rdchk("sys_ctrl", rcs_pkg::ADDR_SYS_CTRL, 8'h00);
        rdchk("tbl_0", 12'ha00, 8'h7f);
        rdchk("tbl_c", 12'ha0c, 8'h32);
        rdchk("tbl_f", 12'ha0f, 8'h80);
        rdchk("tbl_last", rcs_pkg::ADDR_TBL_LAST, 8'hff);
        rdchk("unmapped", 12'h231, 8'h00);
        $display("test reset_values done");

        bus(1'b1, 1'b0, rcs_pkg::ADDR_SYS_CTRL, 8'h0e);
        bus(1'b0, 1'b0, 12'h000, 8'h00);
        chk("antirunt_en", 16'h0000, {15'h0, antirunt_en});
        chk("sync_pdn", 16'h0001, {15'h0, sync_pdn});
        chk("dist_ref_pdn", 16'h0001, {15'h0, dist_ref_pdn});
        rdchk("sys_ctrl", rcs_pkg::ADDR_SYS_CTRL, 8'h0e);
        bus(1'b1, 1'b0, rcs_pkg::ADDR_SYS_CTRL, 8'hf0);
        rdchk("sys_ctrl", rcs_pkg::ADDR_SYS_CTRL, 8'h00);
        chk("antirunt_en", 16'h0001, {15'h0, antirunt_en});
        $display("test system_control done");

        bus(1'b1, 1'b0, rcs_pkg::ADDR_SYS_CTRL, 8'h01);
        chk("sync_hold", 16'h0001, {15'h0, sync_hold});
        chk("sync_event", 16'h0000, {15'h0, sync_event});
        bus(1'b1, 1'b0, rcs_pkg::ADDR_SYS_CTRL, 8'h00);
        chk("sync_hold", 16'h0000, {15'h0, sync_hold});
        chk("sync_event", 16'h0001, {15'h0, sync_event});
        bus(1'b0, 1'b0, 12'h000, 8'h00);
        chk("sync_event", 16'h0000, {15'h0, sync_event});
        $display("test soft_align done");

        sclk_rise = 1'b1;
        bus(1'b1, 1'b0, rcs_pkg::ADDR_UPDATE, 8'h01);
        sclk_rise = 1'b0;
        bus(1'b0, 1'b0, 12'h000, 8'h00);
        chk("commit_pulse", 16'h0000, {15'h0, commit_pulse});
        rdchk("update", rcs_pkg::ADDR_UPDATE, 8'h01);
        chk("commit_pulse", 16'h0000, {15'h0, commit_pulse});
        sclk_rise = 1'b1;
        @(posedge clk);
        #1 sclk_rise = 1'b0;
        chk("commit_pulse", 16'h0001, {15'h0, commit_pulse});
        @(posedge clk);
        #1;
        chk("commit_pulse", 16'h0000, {15'h0, commit_pulse});
        rdchk("update", rcs_pkg::ADDR_UPDATE, 8'h00);
        $display("test update_commit done");

        ex_addr = '{16'h0000, 16'h0080, 16'h0100, 16'h0180, 16'h0200,
                    16'h0, 16'h0, 16'h0};
        ex_len = '{8'h80, 8'h80, 8'h80, 8'h80, 8'h33, 8'h00, 8'h00, 8'h00};
        walk(5, 1);
        bus(1'b1, 1'b0, rcs_pkg::ADDR_XFER_STAT, 8'h01);
        rdchk("xfer_stat", rcs_pkg::ADDR_XFER_STAT, 8'h00);
        $display("test default_walk done");

        // Two spans, commit, end; later default bytes are never reached
        bus(1'b1, 1'b0, 12'ha00, 8'h01);
        bus(1'b1, 1'b0, 12'ha01, 8'h12);
        bus(1'b1, 1'b0, 12'ha02, 8'h34);
        bus(1'b1, 1'b0, 12'ha03, 8'h00);
        bus(1'b1, 1'b0, 12'ha04, 8'h02);
        bus(1'b1, 1'b0, 12'ha05, 8'h30);
        bus(1'b1, 1'b0, 12'ha06, 8'h80);
        bus(1'b1, 1'b0, 12'ha07, 8'hff);
        rdchk("tbl_7", 12'ha07, 8'hff);
        rdchk("tbl_last", rcs_pkg::ADDR_TBL_LAST, 8'hff);
        rdchk("tbl_1", 12'ha01, 8'h12);
        ex_addr[0] = 16'h1234;
        ex_len[0] = 8'h02;
        ex_addr[1] = 16'h0230;
        ex_len[1] = 8'h01;
        walk(2, 1);
        $display("test custom_walk done");

        // Immediate end opcode
        bus(1'b1, 1'b0, 12'ha00, 8'hff);
        bus(1'b0, 1'b0, 12'h000, 8'h00);
        walk(0, 0);
        $display("test end_only done");
        end_of_test();
    end

endmodule // testbench

`default_nettype wire
